/* core/pmc_pkg.sv */
// package for the power mode and peripheral clock control block
// assumes a 32-bit apb slave on the processor clock
package pmc_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] PMC_MODE_OFS = 8'h00;
    localparam logic [7:0] PMC_PWREN_OFS = 8'h04;
    localparam logic [7:0] PMC_DIV_OFS = 8'h08;
    localparam logic [7:0] PMC_MAP_OFS = 8'h0C;
    localparam logic [7:0] PMC_EXTMODE_OFS = 8'h10;
    localparam logic [7:0] PMC_WAKE_OFS = 8'h14;
    localparam logic [7:0] PMC_EXTSTAT_OFS = 8'h18;
    localparam logic [7:0] PMC_SRCSEL_OFS = 8'h1C;
    localparam logic [7:0] PMC_STATE_OFS = 8'h20;
    // ----------------------------------------
    // field positions and sizes
    // ----------------------------------------
    localparam int PMC_IDLE_BIT = 0;
    localparam int PMC_PD_BIT = 1;
    localparam int PMC_NUM_EXT = 9;
    localparam int PMC_NUM_IRQ = 4;
    localparam int PMC_NUM_PERIPH = 16;
    // ----------------------------------------
    // reset values and encodings
    // ----------------------------------------
    localparam logic [1:0] PMC_DIV_QUARTER = 2'h0;
    localparam logic [1:0] PMC_DIV_FULL = 2'h1;
    localparam logic [1:0] PMC_DIV_HALF = 2'h2;
    localparam logic [1:0] PMC_DIV_RST = PMC_DIV_QUARTER;
    localparam logic [15:0] PMC_PWREN_RST = 16'hFFFF;
    localparam logic [17:0] PMC_SRCSEL_RST = 18'h0;
    // ----------------------------------------
    // wake-up timer and power mode states
    // ----------------------------------------
    localparam int PMC_WAKE_CYCLES = 4096;
    typedef enum logic [3:0] {
        PMC_RUN = 4'b0001,
        PMC_IDLE = 4'b0010,
        PMC_PDOWN = 4'b0100,
        PMC_WAKE = 4'b1000
    } pmc_state_t;
endpackage

/* core/pmc_top.sv */
// power modes, peripheral power gating, peripheral clock divider, vector map
// assumes an apb master on CLOCK and gate cells downstream of the enables
`timescale 1ns/1ps
`default_nettype none
module pmc_top
    import pmc_pkg::*;
#(
    parameter int WAKE_CYCLES = PMC_WAKE_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [pmc_pkg::PMC_NUM_EXT-1:0] EXT_IN,
    input wire logic PERIPH_IRQ,
    input wire logic PLL_RUNNING,
    output logic CPU_CLK_EN,
    output logic PCLK_EN,
    output logic [pmc_pkg::PMC_NUM_PERIPH-1:0] PERIPH_PWR_EN,
    output logic OSC_EN,
    output logic PLL_KEEP,
    output logic PIN_HOLD,
    output logic VEC_MAP_SRAM,
    output logic [pmc_pkg::PMC_NUM_IRQ-1:0] EXT_IRQ
);
    import pmc_pkg::*;
    // ----------------------------------------
    // reset release and input sync
    // ----------------------------------------
    logic rst_s1_q, rst_b_q;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_b_q <= rst_s1_q;
        end
    end
    logic [PMC_NUM_EXT-1:0] ext_s1_q, ext_s2_q, ext_prev_q;
    always_ff @(posedge CLOCK or negedge rst_b_q) begin
        if (!rst_b_q) begin
            ext_s1_q <= '0;
            ext_s2_q <= '0;
            ext_prev_q <= '0;
        end else begin
            ext_s1_q <= EXT_IN;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
        end
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [1:0] mode_q;
    logic [PMC_NUM_PERIPH-1:0] pwren_q;
    logic [1:0] div_q;
    logic map_q;
    logic [PMC_NUM_EXT-1:0] extmode_q, wake_q, extstat_q;
    logic [17:0] srcsel_q;
    pmc_state_t state_q;
    logic wr, rd, wake_evt;
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    // ----------------------------------------
    // access decode
    // ----------------------------------------
    // one write strobe per register, shared by the flag, mode and check logic
    function automatic logic wr_at(input logic [7:0] ofs);
        return PSEL && PENABLE && PWRITE && (PADDR == ofs);
    endfunction
    // external event detection: edge inputs catch rising edges, level inputs follow high
    logic [PMC_NUM_EXT-1:0] ext_hit;
    assign ext_hit = (extmode_q & ext_s2_q & ~ext_prev_q) | (~extmode_q & ext_s2_q);
    always_ff @(posedge CLOCK or negedge rst_b_q) begin
        if (!rst_b_q) begin
            pwren_q <= PMC_PWREN_RST;
            div_q <= PMC_DIV_RST;
            map_q <= 1'b0;
            extmode_q <= '0;
            wake_q <= '0;
            srcsel_q <= PMC_SRCSEL_RST;
        end else if (wr) begin
            case (PADDR)
                PMC_PWREN_OFS: pwren_q <= PWDATA[PMC_NUM_PERIPH-1:0];
                PMC_DIV_OFS: div_q <= PWDATA[1:0];
                PMC_MAP_OFS: map_q <= PWDATA[0];
                PMC_EXTMODE_OFS: extmode_q <= PWDATA[PMC_NUM_EXT-1:0];
                PMC_WAKE_OFS: wake_q <= PWDATA[PMC_NUM_EXT-1:0];
                PMC_SRCSEL_OFS: srcsel_q <= PWDATA[17:0];
                default: ;
            endcase
        end
    end
    // sticky flags: write one clears, a new hit in the same cycle wins
    always_ff @(posedge CLOCK or negedge rst_b_q) begin
        if (!rst_b_q) begin
            extstat_q <= '0;
        end else begin
            extstat_q <= (wr_at(PMC_EXTSTAT_OFS) ?
                          (extstat_q & ~PWDATA[PMC_NUM_EXT-1:0]) : extstat_q) | ext_hit;
        end
    end
    // each input picks one of four request lines with two select bits
    function automatic logic [PMC_NUM_IRQ-1:0] route(input logic [PMC_NUM_EXT-1:0] f,
                                                    input logic [17:0] sel);
        logic [PMC_NUM_IRQ-1:0] r;
        r = '0;
        for (int i = 0; i < PMC_NUM_EXT; i++) begin
            r[sel[2*i +: 2]] = r[sel[2*i +: 2]] | f[i];
        end
        return r;
    endfunction
    always_ff @(posedge CLOCK or negedge rst_b_q) begin
        if (!rst_b_q) begin
            EXT_IRQ <= '0;
        end else begin
            EXT_IRQ <= route(extstat_q, srcsel_q);
        end
    end
    // ----------------------------------------
    // power mode state machine
    // ----------------------------------------
    // ext pins are sampled on CLOCK; the oscillator is modelled as gated, not stopped,
    // so the raw input path stands in for the clockless wake detector
    logic [12:0] wake_cnt_q;
    logic irq_any;
    assign irq_any = PERIPH_IRQ || (|extstat_q) || (|ext_hit);
    assign wake_evt = |(wake_q & ext_s2_q);
    always_ff @(posedge CLOCK or negedge rst_b_q) begin
        if (!rst_b_q) begin
            state_q <= PMC_RUN;
            mode_q <= 2'b00;
            wake_cnt_q <= '0;
        end else begin
            case (state_q)
                PMC_RUN: begin
                    if (wr_at(PMC_MODE_OFS)) begin
                        mode_q <= PWDATA[1:0];
                        if (PWDATA[PMC_PD_BIT]) begin
                            state_q <= PMC_PDOWN;
                        end else if (PWDATA[PMC_IDLE_BIT]) begin
                            state_q <= PMC_IDLE;
                        end
                    end
                end
                PMC_IDLE: begin
                    if (irq_any) begin
                        state_q <= PMC_RUN;
                        mode_q <= 2'b00;
                    end
                end
                PMC_PDOWN: begin
                    if (wake_evt) begin
                        state_q <= PMC_WAKE;
                        wake_cnt_q <= 13'(WAKE_CYCLES - 1);
                    end
                end
                PMC_WAKE: begin
                    if (wake_cnt_q == '0) begin
                        state_q <= PMC_RUN;
                        mode_q <= 2'b00;
                    end else begin
                        wake_cnt_q <= wake_cnt_q - 13'h1;
                    end
                end
                default: state_q <= PMC_RUN;
            endcase
        end
    end
    // ----------------------------------------
    // clock divider and gating
    // ----------------------------------------
    logic [1:0] div_cnt_q;
    logic pclk_tick;
    always_comb begin
        case (div_q)
            PMC_DIV_FULL: pclk_tick = 1'b1;
            PMC_DIV_HALF: pclk_tick = div_cnt_q[0];
            default: pclk_tick = (div_cnt_q == 2'h3);
        endcase
    end
    always_ff @(posedge CLOCK or negedge rst_b_q) begin
        if (!rst_b_q) begin
            div_cnt_q <= 2'h0;
        end else begin
            div_cnt_q <= div_cnt_q + 2'h1;
        end
    end
    logic run_nxt, pd_nxt;
    assign pd_nxt = (state_q == PMC_PDOWN) || (state_q == PMC_WAKE);
    assign run_nxt = (state_q == PMC_RUN);
    always_ff @(posedge CLOCK or negedge rst_b_q) begin
        if (!rst_b_q) begin
            CPU_CLK_EN <= 1'b0;
            PCLK_EN <= 1'b0;
            PERIPH_PWR_EN <= PMC_PWREN_RST;
            OSC_EN <= 1'b1;
            PLL_KEEP <= 1'b0;
            PIN_HOLD <= 1'b0;
            VEC_MAP_SRAM <= 1'b0;
        end else begin
            CPU_CLK_EN <= run_nxt;
            PCLK_EN <= pclk_tick && !pd_nxt;
            PERIPH_PWR_EN <= pwren_q;
            OSC_EN <= (state_q != PMC_PDOWN);
            PLL_KEEP <= PLL_RUNNING && (state_q != PMC_PDOWN);
            PIN_HOLD <= pd_nxt;
            VEC_MAP_SRAM <= map_q;
        end
    end
    // ----------------------------------------
    // apb read side
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge rst_b_q) begin
        if (!rst_b_q) begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    PMC_MODE_OFS: PRDATA <= {30'h0, mode_q};
                    PMC_PWREN_OFS: PRDATA <= {16'h0, pwren_q};
                    PMC_DIV_OFS: PRDATA <= {30'h0, div_q};
                    PMC_MAP_OFS: PRDATA <= {31'h0, map_q};
                    PMC_EXTMODE_OFS: PRDATA <= {23'h0, extmode_q};
                    PMC_WAKE_OFS: PRDATA <= {23'h0, wake_q};
                    PMC_EXTSTAT_OFS: PRDATA <= {23'h0, extstat_q};
                    PMC_SRCSEL_OFS: PRDATA <= {14'h0, srcsel_q};
                    PMC_STATE_OFS: PRDATA <= {28'h0, state_q};
                    default: PSLVERR <= 1'b1;
                endcase
            end
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_b_q);
    idle_cpu_gate_a: assert property (state_q == PMC_IDLE |=> !CPU_CLK_EN)
        else $error("cpu clock runs in idle");
    idle_pclk_runs_a: assert property (state_q == PMC_IDLE && div_q == PMC_DIV_FULL
        && $past(div_q) == PMC_DIV_FULL |=> PCLK_EN)
        else $error("peripheral clock stopped in idle");
    pd_osc_off_a: assert property (state_q == PMC_PDOWN |=> !OSC_EN && !PCLK_EN)
        else $error("clock alive in power-down");
    pd_pin_hold_a: assert property (state_q == PMC_PDOWN |=> PIN_HOLD)
        else $error("pins not held in power-down");
    pd_exit_cause_a: assert property (state_q == PMC_PDOWN && !wake_evt
        |=> state_q == PMC_PDOWN)
        else $error("power-down left without wake");
    wake_mask_a: assert property (state_q == PMC_PDOWN && wake_q == '0
        |=> state_q == PMC_PDOWN)
        else $error("masked input woke the chip");
    vec_map_a: assert property (wr && PADDR == PMC_MAP_OFS |=> ##1 VEC_MAP_SRAM == $past(PWDATA[0], 2))
        else $error("vector map not applied");
    pwr_en_a: assert property (##1 PERIPH_PWR_EN == $past(pwren_q))
        else $error("power enable mismatch");
    quarter_rate_a: assert property (div_q == PMC_DIV_QUARTER && state_q == PMC_RUN && PCLK_EN
        |=> !PCLK_EN [*3])
        else $error("quarter divider wrong");
    wake_timer_a: assert property (state_q == PMC_WAKE |=> !CPU_CLK_EN)
        else $error("cpu ran before wake timer");
    mode_clear_a: assert property (state_q != PMC_RUN ##1 state_q == PMC_RUN |-> mode_q == 2'b00)
        else $error("mode bit not cleared");
    // bus handshake: zero wait states, one-cycle ready, error on addresses above the top of the map
    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready stood too long");
    unmapped_err_a: assert property (PSEL && !PENABLE && PADDR > PMC_STATE_OFS
        |=> PSLVERR)
        else $error("no error for unmapped address");
    flag_set_a: assert property ((ext_hit & ~extstat_q) != '0 |=> extstat_q != '0)
        else $error("external hit lost");
    pd_cpu_off_a: assert property (state_q == PMC_PDOWN |=> !CPU_CLK_EN)
        else $error("cpu clock in power-down");
    cpu_run_a: assert property (state_q == PMC_RUN |=> CPU_CLK_EN)
        else $error("cpu clock stopped in run");
    hold_release_a: assert property (state_q == PMC_RUN |=> !PIN_HOLD)
        else $error("pins held in run");
    osc_back_a: assert property (state_q == PMC_RUN |=> OSC_EN)
        else $error("oscillator off in run");
    timer_start_a: assert property (state_q == PMC_PDOWN && wake_evt
        |=> state_q == PMC_WAKE && wake_cnt_q == 13'(WAKE_CYCLES - 1))
        else $error("wake timer not started");
    timer_hold_a: assert property (state_q == PMC_WAKE && wake_cnt_q != '0
        |=> state_q == PMC_WAKE)
        else $error("wake timer cut short");
    idle_exit_a: assert property (state_q == PMC_IDLE && irq_any |=> state_q == PMC_RUN)
        else $error("interrupt did not end idle");
    pll_keep_a: assert property (PLL_RUNNING && state_q == PMC_IDLE |=> PLL_KEEP)
        else $error("pll dropped in idle");
    mode_enter_a: assert property (state_q == PMC_RUN && wr_at(PMC_MODE_OFS)
        && PWDATA[PMC_PD_BIT] |=> state_q == PMC_PDOWN)
        else $error("power-down not entered");
    full_rate_a: assert property (div_q == PMC_DIV_FULL && $past(div_q) == PMC_DIV_FULL
        && !pd_nxt |=> PCLK_EN)
        else $error("full rate divider wrong");
    half_rate_a: assert property (div_q == PMC_DIV_HALF && $past(div_q) == PMC_DIV_HALF
        && PCLK_EN |=> !PCLK_EN)
        else $error("half rate divider wrong");
    idle_wake_c: cover property (state_q == PMC_IDLE ##1 state_q == PMC_RUN);
    pd_enter_c: cover property (state_q == PMC_RUN ##1 state_q == PMC_PDOWN);
    idle_enter_c: cover property (state_q == PMC_RUN ##1 state_q == PMC_IDLE);
    pd_wake_c: cover property (state_q == PMC_WAKE ##1 state_q == PMC_RUN);
    ext_irq_c: cover property (|EXT_IRQ);
endmodule // pmc_top
`default_nettype wire

/* verification/pmc_far_model.sv */
// model of the peripheral clock consumer, pll and interrupt source around the power block
// assumes one clock; the enables qualify that clock for each consumer
`timescale 1ns/1ps
`default_nettype none
module pmc_far_model (
    input wire logic clk,
    input wire logic pclk_en,
    input wire logic irq_req,
    output logic periph_irq,
    output logic pll_running,
    output int pclk_cnt
);
    // --------------------------------
    // peripherals tick only on enabled edges
    // --------------------------------
    // the pll stays up, so its keep output must follow it outside power-down
    assign pll_running = 1'b1;
    assign periph_irq = irq_req;
    initial pclk_cnt = 0;
    always @(posedge clk) begin
        pclk_cnt <= pclk_cnt + (pclk_en ? 1 : 0);
    end
endmodule // pmc_far_model
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the power mode and peripheral clock block
// assumes pmc_top and pmc_far_model; short wake timer for speed
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmc_pkg::*;
    localparam int WK = 8;
    logic CLOCK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic PREADY, PSLVERR, PERIPH_IRQ, PLL_RUNNING, CPU_CLK_EN, PCLK_EN, OSC_EN;
    logic PLL_KEEP, PIN_HOLD, VEC_MAP_SRAM, irq_req = 1'b0;
    logic [8:0] EXT_IN = 9'h0;
    logic [15:0] PERIPH_PWR_EN;
    logic [3:0] EXT_IRQ;
    int pclk_cnt, err_total = 0, checked = 0, cycles = 0, n;
    pmc_top #(.WAKE_CYCLES(WK)) pmc_top_i (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_IN(EXT_IN), .PERIPH_IRQ(PERIPH_IRQ),
        .PLL_RUNNING(PLL_RUNNING), .CPU_CLK_EN(CPU_CLK_EN), .PCLK_EN(PCLK_EN),
        .PERIPH_PWR_EN(PERIPH_PWR_EN), .OSC_EN(OSC_EN), .PLL_KEEP(PLL_KEEP),
        .PIN_HOLD(PIN_HOLD), .VEC_MAP_SRAM(VEC_MAP_SRAM), .EXT_IRQ(EXT_IRQ));
    pmc_far_model pmc_far_model_i (.clk(CLOCK), .pclk_en(PCLK_EN), .irq_req(irq_req),
        .periph_irq(PERIPH_IRQ), .pll_running(PLL_RUNNING), .pclk_cnt(pclk_cnt));
    always #20 CLOCK = ~CLOCK;
    // --------------------------------
    // shared tasks
    // --------------------------------
    task report_and_stop;
        $display("counts: checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PADDR <= a;
        PWRITE <= w;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        // no timeout here: PREADY ends this wait, or the hang guard if it never comes
        do begin
            @(posedge CLOCK);
        end while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(nm, exp, r);
    endtask
    // count peripheral clock pulses over sixteen cpu clock edges
    task rate(input string nm, input int exp);
        int c0;
        // let a new divider setting reach the registered enable first
        repeat (2) @(posedge CLOCK);
        c0 = pclk_cnt;
        repeat (16) @(posedge CLOCK);
        chk(nm, exp, pclk_cnt - c0);
    endtask
    task wait_cpu;
        n = 0;
        while (CPU_CLK_EN !== 1'b1 && n < 100) begin
            @(posedge CLOCK);
            n++;
        end
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task t_reset_div;
        logic [31:0] r;
        logic e;
        chk("pwr_en", 32'hFFFF, PERIPH_PWR_EN);
        chk("osc_en", 32'h1, OSC_EN);
        rdc("div", PMC_DIV_OFS, 32'h0);
        rate("rate_rst", 4);
        wr(PMC_DIV_OFS, 32'h1);
        rate("rate_full", 16);
        wr(PMC_DIV_OFS, 32'h2);
        rate("rate_half", 8);
        wr(PMC_DIV_OFS, 32'h3);
        rate("rate_qtr", 4);
        wr(PMC_PWREN_OFS, 32'h00F0);
        repeat (2) @(posedge CLOCK);
        chk("pwr_en", 32'h00F0, PERIPH_PWR_EN);
        wr(PMC_MAP_OFS, 32'h1);
        repeat (2) @(posedge CLOCK);
        chk("vec_map", 32'h1, VEC_MAP_SRAM);
        apb(8'h40, 1'b0, 32'h0, r, e);
        chk("unmapped_err", 32'h1, e);
        $display("test reset and divider done");
    endtask
    task t_idle;
        wr(PMC_MODE_OFS, 32'h1);
        repeat (3) @(posedge CLOCK);
        chk("cpu_en_idle", 32'h0, CPU_CLK_EN);
        chk("pll_keep", 32'h1, PLL_KEEP);
        rdc("state_idle", PMC_STATE_OFS, 32'h2);
        rate("rate_idle", 4);
        irq_req <= 1'b1;
        wait_cpu();
        chk("idle_wake", 32'h1, n <= 10);
        irq_req <= 1'b0;
        rdc("mode_clr", PMC_MODE_OFS, 32'h0);
        $display("test idle done");
    endtask
    task t_pdown;
        wr(PMC_WAKE_OFS, 32'h008);
        wr(PMC_MODE_OFS, 32'h2);
        repeat (3) @(posedge CLOCK);
        chk("osc_pd", 32'h0, OSC_EN);
        chk("hold_pd", 32'h1, PIN_HOLD);
        rate("rate_pd", 0);
        EXT_IN <= 9'h001;
        repeat (10) @(posedge CLOCK);
        chk("no_wake", 32'h0, CPU_CLK_EN);
        EXT_IN <= 9'h009;
        wait_cpu();
        chk("wake_time", 32'h1, n >= WK + 1 && n <= WK + 10);
        EXT_IN <= 9'h000;
        chk("pwr_kept", 32'h00F0, PERIPH_PWR_EN);
        chk("osc_back", 32'h1, OSC_EN);
        rdc("mode_clr", PMC_MODE_OFS, 32'h0);
        rdc("state_run", PMC_STATE_OFS, 32'h1);
        wr(PMC_EXTSTAT_OFS, 32'h1FF);
        $display("test power-down done");
    endtask
    task t_ext;
        wr(PMC_EXTMODE_OFS, 32'h020);
        wr(PMC_SRCSEL_OFS, 32'h00800);
        EXT_IN <= 9'h020;
        repeat (3) @(posedge CLOCK);
        EXT_IN <= 9'h000;
        repeat (4) @(posedge CLOCK);
        chk("ext_irq", 32'h4, EXT_IRQ);
        rdc("ext_flag", PMC_EXTSTAT_OFS, 32'h020);
        wr(PMC_EXTSTAT_OFS, 32'h020);
        repeat (2) @(posedge CLOCK);
        chk("ext_irq_clr", 32'h0, EXT_IRQ);
        $display("test external inputs done");
    endtask
    initial begin
        repeat (3) @(posedge CLOCK);
        RST_B <= 1'b1;
        repeat (3) @(posedge CLOCK);
        t_reset_div();
        t_idle();
        t_pdown();
        t_ext();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
